// ---- inc/hbmd_regs.svh ----
// register offsets, field positions, reset values and timing counts of the bridge decoder
`ifndef HBMD_REGS_SVH
`define HBMD_REGS_SVH
`define HBMD_CLK_PERIOD_NS      100
`define HBMD_SETTLE_NS          1000
`define HBMD_SETTLE_CYC         ((`HBMD_SETTLE_NS + `HBMD_CLK_PERIOD_NS - 1) / `HBMD_CLK_PERIOD_NS)
`define HBMD_OFS_CONTROL_ONE    8'h00
`define HBMD_OFS_CONTROL_THREE  8'h04
`define HBMD_OFS_STATUS         8'h08
`define HBMD_MODE_LSB           0
`define HBMD_HIZ_A_BIT          0
`define HBMD_HIZ_B_BIT          1
`define HBMD_ST_MODE_LSB        0
`define HBMD_ST_RUN_BIT         2
`define HBMD_ST_FAULT_LSB       3
`define HBMD_ST_OE_LSB          5
`define HBMD_ST_LVL_LSB         7
`define HBMD_MODE_RESET         2'h1
`define HBMD_HIZ_RESET          2'h0
`define HBMD_STRAP_LOW          2'h0
`define HBMD_STRAP_SUPPLY       2'h1
`define HBMD_STRAP_RESISTOR     2'h2
`define HBMD_PIN_W              8
`endif

// ---- inc/hbmd_pkg.sv ----
// types of the bridge input mode decoder
package hbmd_pkg;
  typedef enum logic [1:0] {
    HBMD_MODE_PHEN = 2'h0,
    HBMD_MODE_PWM  = 2'h1,
    HBMD_MODE_IND  = 2'h2,
    HBMD_MODE_OFF  = 2'h3
  } hbmd_mode_e;
  typedef enum logic [2:0] {
    HBMD_ST_OFF    = 3'h1,
    HBMD_ST_SETTLE = 3'h2,
    HBMD_ST_RUN    = 3'h4
  } hbmd_state_e;
  typedef logic [3:0] hbmd_cnt_t;
endpackage

// ---- rtl/hbmd_decoder.sv ----
// h-bridge input mode decoder with apb register access
`timescale 1ns/1ns
`default_nettype none
`include "hbmd_regs.svh"
module hbmd_decoder #(
  parameter bit SERIAL_VARIANT = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_low_active,
  input  wire logic        disable_in,
  input  wire logic        input_a_enable,
  input  wire logic        input_b_phase,
  input  wire logic [1:0]  mode_strap_level,
  input  wire logic [1:0]  overcurrent_fault,
  output logic             internal_logic_supply,
  output logic             half_bridge_out_a,
  output logic             half_bridge_out_a_oe,
  output logic             half_bridge_out_b,
  output logic             half_bridge_out_b_oe
);
  import hbmd_pkg::*;

  // pin synchronisers, one generate loop over the bits
  logic [`HBMD_PIN_W-1:0] pin_raw;
  logic [`HBMD_PIN_W-1:0] pin_meta;
  logic [`HBMD_PIN_W-1:0] pin_sync;
  assign pin_raw = {overcurrent_fault, mode_strap_level, input_b_phase,
                    input_a_enable, disable_in, sleep_low_active};
  genvar gi;
  generate
    for (gi = 0; gi < `HBMD_PIN_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic       awake;
  logic       dis_s;
  logic       in_a;
  logic       in_b;
  logic [1:0] strap_s;
  logic [1:0] fault_s;
  assign awake   = pin_sync[0];
  assign dis_s   = pin_sync[1];
  assign in_a    = pin_sync[2];
  assign in_b    = pin_sync[3];
  assign strap_s = pin_sync[5:4];
  assign fault_s = pin_sync[7:6];

  // supply and strap latch sequencer
  hbmd_state_e state;
  hbmd_state_e next_state;
  hbmd_cnt_t   settle_cnt;
  hbmd_cnt_t   next_settle_cnt;
  logic        strap_latch;
  localparam hbmd_cnt_t SETTLE_LAST = hbmd_cnt_t'(`HBMD_SETTLE_CYC - 1);

  always_comb begin
    next_state      = state;
    next_settle_cnt = settle_cnt;
    strap_latch     = 1'b0;
    unique case (state)
      HBMD_ST_OFF: begin
        next_settle_cnt = '0;
        if (awake) begin
          next_state = HBMD_ST_SETTLE;
        end
      end
      HBMD_ST_SETTLE: begin
        if (!awake) begin
          next_state = HBMD_ST_OFF;
        end else if (settle_cnt == SETTLE_LAST) begin
          strap_latch = 1'b1;
          next_state  = HBMD_ST_RUN;
        end else begin
          next_settle_cnt = settle_cnt + 1'b1;
        end
      end
      HBMD_ST_RUN: begin
        if (!awake) begin
          next_state = HBMD_ST_OFF;
        end
      end
      default: begin
        next_state = HBMD_ST_OFF;
      end
    endcase
  end

  // supply is up in reset, drops on the first clock after while the synchronised sleep pin reads low, and comes back two clocks later
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state      <= HBMD_ST_SETTLE;
      settle_cnt <= '0;
    end else begin
      state      <= next_state;
      settle_cnt <= next_settle_cnt;
    end
  end
  assign internal_logic_supply = (state != HBMD_ST_OFF);

  // registers and latched mode
  logic [1:0] mode_field;
  logic [1:0] next_mode_field;
  logic [1:0] hiz_bits;
  logic [1:0] next_hiz_bits;
  logic [1:0] active_mode;
  logic [1:0] next_active_mode;
  logic       dis_d;
  logic       dis_fall;
  logic [1:0] strap_mode;
  logic       wr_en;
  logic       setup;
  logic       mapped;

  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && pwrite;
  assign dis_fall = dis_d && !dis_s;
  assign mapped   = (paddr == `HBMD_OFS_CONTROL_ONE) || (paddr == `HBMD_OFS_CONTROL_THREE)
                 || (paddr == `HBMD_OFS_STATUS);

  always_comb begin
    unique case (strap_s)
      `HBMD_STRAP_LOW:      strap_mode = HBMD_MODE_PHEN;
      `HBMD_STRAP_SUPPLY:   strap_mode = HBMD_MODE_PWM;
      `HBMD_STRAP_RESISTOR: strap_mode = HBMD_MODE_IND;
      // no fourth strap level exists; a glitching detector falls back to pwm
      default:              strap_mode = HBMD_MODE_PWM;
    endcase
  end

  always_comb begin
    next_mode_field  = mode_field;
    next_hiz_bits    = hiz_bits;
    next_active_mode = active_mode;
    if (wr_en && paddr == `HBMD_OFS_CONTROL_ONE) begin
      next_mode_field = pwdata[`HBMD_MODE_LSB +: 2];
    end
    if (wr_en && paddr == `HBMD_OFS_CONTROL_THREE) begin
      next_hiz_bits = {pwdata[`HBMD_HIZ_B_BIT], pwdata[`HBMD_HIZ_A_BIT]};
    end
    if (SERIAL_VARIANT) begin
      if (dis_fall) begin
        next_active_mode = mode_field;
      end
    end else if (strap_latch) begin
      next_active_mode = strap_mode;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_field  <= `HBMD_MODE_RESET;
      hiz_bits    <= `HBMD_HIZ_RESET;
      active_mode <= `HBMD_MODE_RESET;
      dis_d       <= 1'b0;
    end else begin
      mode_field  <= next_mode_field;
      hiz_bits    <= next_hiz_bits;
      active_mode <= next_active_mode;
      dis_d       <= dis_s;
    end
  end

  // output decode
  logic [1:0] oe;
  logic [1:0] lvl;
  logic       bridge_on;
  logic [1:0] hiz_eff;
  assign bridge_on = awake && !dis_s && (state == HBMD_ST_RUN);
  assign hiz_eff   = SERIAL_VARIANT ? hiz_bits : 2'h0;

  always_comb begin
    oe  = 2'h0;
    lvl = 2'h0;
    if (bridge_on) begin
      unique case (active_mode)
        HBMD_MODE_PHEN: begin
          oe  = 2'h3;
          lvl = !in_a ? 2'h3 : (in_b ? 2'h1 : 2'h2);
        end
        HBMD_MODE_PWM: begin
          oe  = (in_a || in_b) ? 2'h3 : 2'h0;
          lvl = {in_b, in_a};
        end
        HBMD_MODE_IND: begin
          oe  = ~fault_s & ~hiz_eff;
          lvl = {in_b, in_a};
        end
        HBMD_MODE_OFF: begin
          oe  = 2'h0;
          lvl = 2'h0;
        end
      endcase
      // outside independent mode a fault on either side shuts the whole bridge
      if (active_mode != HBMD_MODE_IND && fault_s != 2'h0) begin
        oe = 2'h0;
      end
    end
  end
  assign half_bridge_out_a    = lvl[0] & oe[0];
  assign half_bridge_out_a_oe = oe[0];
  assign half_bridge_out_b    = lvl[1] & oe[1];
  assign half_bridge_out_b_oe = oe[1];

  // apb read data captured in setup so the access phase finishes with no wait state
  logic [31:0] rd_val;
  logic [31:0] next_prdata;
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `HBMD_OFS_CONTROL_ONE:   rd_val[`HBMD_MODE_LSB +: 2] = mode_field;
      `HBMD_OFS_CONTROL_THREE: rd_val[1:0] = {hiz_bits[1], hiz_bits[0]};
      `HBMD_OFS_STATUS: begin
        rd_val[`HBMD_ST_MODE_LSB +: 2]  = active_mode;
        rd_val[`HBMD_ST_RUN_BIT]        = (state == HBMD_ST_RUN);
        rd_val[`HBMD_ST_FAULT_LSB +: 2] = fault_s;
        rd_val[`HBMD_ST_OE_LSB +: 2]    = oe;
        rd_val[`HBMD_ST_LVL_LSB +: 2]   = lvl & oe;
      end
      default: rd_val = 32'h0000_0000;
    endcase
    next_prdata = setup && !pwrite ? rd_val : prdata;
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_sleep_hiz;
    !awake |-> oe == 2'h0;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("output driven while asleep");

  property p_dis_hiz;
    awake && dis_s |-> !half_bridge_out_a_oe && !half_bridge_out_b_oe;
  endproperty
  a_dis_hiz: assert property (p_dis_hiz) else $error("output driven while disabled");

  property p_mode_off;
    active_mode == HBMD_MODE_OFF |-> oe == 2'h0;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode 11 drives an output");

  property p_phen_brake;
    bridge_on && active_mode == HBMD_MODE_PHEN && fault_s == 2'h0 && !in_a
      |-> half_bridge_out_a && half_bridge_out_b && oe == 2'h3;
  endproperty
  a_phen_brake: assert property (p_phen_brake) else $error("phase/enable brake wrong");

  property p_phen_dir;
    bridge_on && active_mode == HBMD_MODE_PHEN && fault_s == 2'h0 && in_a
      |-> half_bridge_out_a == in_b && half_bridge_out_b == !in_b;
  endproperty
  a_phen_dir: assert property (p_phen_dir) else $error("phase/enable direction wrong");

  property p_pwm_coast;
    bridge_on && active_mode == HBMD_MODE_PWM && !in_a && !in_b |-> oe == 2'h0;
  endproperty
  a_pwm_coast: assert property (p_pwm_coast) else $error("pwm 00 not high impedance");

  property p_ind_follow;
    bridge_on && active_mode == HBMD_MODE_IND && fault_s == 2'h0 && hiz_eff == 2'h0
      |-> oe == 2'h3 && half_bridge_out_a == in_a && half_bridge_out_b == in_b;
  endproperty
  a_ind_follow: assert property (p_ind_follow) else $error("independent output not following");

  property p_fault_iso;
    bridge_on && active_mode == HBMD_MODE_IND && fault_s == 2'h1 && !hiz_eff[1]
      |-> !half_bridge_out_a_oe && half_bridge_out_b_oe;
  endproperty
  a_fault_iso: assert property (p_fault_iso) else $error("fault not isolated");

  property p_hiz_bit;
    SERIAL_VARIANT && active_mode == HBMD_MODE_IND && hiz_bits[1] |-> !half_bridge_out_b_oe;
  endproperty
  a_hiz_bit: assert property (p_hiz_bit) else $error("hiz bit ignored");

  property p_mode_take;
    SERIAL_VARIANT && dis_fall |=> active_mode == $past(mode_field);
  endproperty
  a_mode_take: assert property (p_mode_take) else $error("mode not taken on disable fall");

  property p_mode_hold;
    SERIAL_VARIANT && !dis_fall |=> $stable(active_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without disable fall");

  property p_strap_hold;
    !SERIAL_VARIANT && state == HBMD_ST_RUN ##1 state == HBMD_ST_RUN |-> $stable(active_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap mode changed while running");

  property p_supply_first;
    strap_latch |-> internal_logic_supply && $past(internal_logic_supply, 2);
  endproperty
  a_supply_first: assert property (p_supply_first) else $error("strap sampled before supply");

  c_ind_fault: cover property (bridge_on && active_mode == HBMD_MODE_IND && fault_s == 2'h2);
  c_mode_change: cover property (SERIAL_VARIANT && dis_fall && mode_field != active_mode);
  c_sleep_exit: cover property (state == HBMD_ST_OFF ##1 state == HBMD_ST_SETTLE);
  c_pwm_brake: cover property (bridge_on && active_mode == HBMD_MODE_PWM && in_a && in_b);
endmodule // hbmd_decoder
`default_nettype wire

// ---- verification/hbmd_ctrl_model.sv ----
// controller-side pin model that drives the bridge decoder inputs
`timescale 1ns/1ns
`default_nettype none
module hbmd_ctrl_model (
  input  wire logic       clk,
  output var  logic       sleep_low_active,
  output var  logic       disable_in,
  output var  logic       input_a_enable,
  output var  logic       input_b_phase,
  output var  logic [1:0] mode_strap_level,
  output var  logic [1:0] overcurrent_fault
);
  initial begin
    sleep_low_active  = 1'b1;
    disable_in        = 1'b1;
    input_a_enable    = 1'b0;
    input_b_phase     = 1'b0;
    mode_strap_level  = 2'h1;
    overcurrent_fault = 2'h0;
  end
  task automatic set_pins(input logic s, input logic d, input logic a, input logic b);
    @(posedge clk);
    sleep_low_active <= s;
    disable_in       <= d;
    input_a_enable   <= a;
    input_b_phase    <= b;
  endtask
  task automatic set_aux(input logic [1:0] strap, input logic [1:0] flt);
    @(posedge clk);
    mode_strap_level  <= strap;
    overcurrent_fault <= flt;
  endtask
  // speed is chopped between drive and brake so the load never coasts through hi-z
  task automatic chop(input int n);
    repeat (n) begin
      set_pins(1'b1, 1'b0, 1'b1, 1'b0);
      repeat (3) @(posedge clk);
      set_pins(1'b1, 1'b0, 1'b1, 1'b1);
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // hbmd_ctrl_model
`default_nettype wire

// ---- verification/hbmd_decoder_tb.sv ----
// self-checking bench for the bridge input mode decoder, serial and strap variants
`timescale 1ns/1ns
`default_nettype none
`include "hbmd_regs.svh"
module hbmd_decoder_tb;
  import hbmd_pkg::*;
  logic        ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic        pready, pslverr, supply, oa, oa_oe, ob, ob_oe, supply_hw, ha, ha_oe, hb, hb_oe;
  logic        sleep_low_active, disable_in, input_a_enable, input_b_phase;
  logic [1:0]  mode_strap_level, overcurrent_fault;
  int          n_fail = 0, n_compared = 0, cyc = 0;
  wire  [3:0]  outs = {oa_oe, oa, ob_oe, ob};
  wire  [3:0]  outs_hw = {ha_oe, ha, hb_oe, hb};

  hbmd_ctrl_model pm (.clk(ref_clk), .sleep_low_active(sleep_low_active), .disable_in(disable_in),
    .input_a_enable(input_a_enable), .input_b_phase(input_b_phase), .mode_strap_level(mode_strap_level),
    .overcurrent_fault(overcurrent_fault));
  hbmd_decoder uut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_low_active(sleep_low_active), .disable_in(disable_in), .input_a_enable(input_a_enable),
    .input_b_phase(input_b_phase), .mode_strap_level(mode_strap_level), .overcurrent_fault(overcurrent_fault),
    .internal_logic_supply(supply), .half_bridge_out_a(oa), .half_bridge_out_a_oe(oa_oe),
    .half_bridge_out_b(ob), .half_bridge_out_b_oe(ob_oe));
  // strap variant shares the bus so hiz writes can be shown to leave its outputs alone
  hbmd_decoder #(.SERIAL_VARIANT(1'b0)) uut_hw (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .sleep_low_active(sleep_low_active), .disable_in(disable_in), .input_a_enable(input_a_enable),
    .input_b_phase(input_b_phase), .mode_strap_level(mode_strap_level), .overcurrent_fault(overcurrent_fault),
    .internal_logic_supply(supply_hw), .half_bridge_out_a(ha), .half_bridge_out_a_oe(ha_oe),
    .half_bridge_out_b(hb), .half_bridge_out_b_oe(hb_oe));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    chk32({28'h0, got}, {28'h0, exp});
  endtask
  // waits whole cycles, then samples mid-cycle where outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never gets its answer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [3:0] exp_out(input logic [1:0] m, input logic a, input logic b);
    case (m)
      HBMD_MODE_PHEN: exp_out = !a ? 4'hf : (b ? 4'he : 4'hb);
      HBMD_MODE_PWM:  exp_out = {a | b, a, a | b, b};
      HBMD_MODE_IND:  exp_out = {1'b1, a, 1'b1, b};
      default:        exp_out = 4'h0;
    endcase
  endfunction
  task automatic latch(input logic [1:0] m);
    apb(1'b1, `HBMD_OFS_CONTROL_ONE, {30'h0, m}, rd);
    pm.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
    settle(3);
    pm.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    settle(5);
  endtask
  task automatic status_mode(input logic [1:0] m);
    apb(1'b0, `HBMD_OFS_STATUS, 32'h0, rd);
    chk32({30'h0, rd[1:0]}, {30'h0, m});
  endtask

  task automatic t_regs();
    apb(1'b0, `HBMD_OFS_CONTROL_ONE, 32'h0, rd);
    chk32(rd, 32'h0000_0001);
    apb(1'b0, `HBMD_OFS_CONTROL_THREE, 32'h0, rd);
    chk32(rd, 32'h0000_0000);
    apb(1'b0, 8'h0c, 32'h0, rd);
    chk32({rd[30:0], err}, 32'h0000_0001);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      latch(m[1:0]);
      status_mode(m[1:0]);
      for (int i = 0; i < 4; i++) begin
        pm.set_pins(1'b1, 1'b0, i[1], i[0]);
        settle(4);
        chk4(outs, exp_out(m[1:0], i[1], i[0]));
        chk4(outs_hw, exp_out(2'h1, i[1], i[0]));
      end
    end
  endtask
  task automatic t_latch();
    apb(1'b1, `HBMD_OFS_CONTROL_ONE, 32'h0000_0000, rd);
    settle(4);
    status_mode(2'h3);
    chk4(outs, 4'h0);
    latch(2'h0);
    status_mode(2'h0);
  endtask
  task automatic t_gate();
    settle(4);
    chk4(outs, 4'hf);
    pm.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
    settle(4);
    chk4(outs, 4'h0);
    pm.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    settle(4);
    chk4(outs | outs_hw, 4'h0);
    chk4({supply, supply_hw, 2'h0}, 4'h0);
    pm.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    settle(16);
    chk4(outs, 4'hf);
    chk4({supply, supply_hw, 2'h0}, 4'hc);
  endtask
  task automatic t_ind();
    latch(2'h2);
    pm.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
    pm.set_aux(2'h1, 2'h1);
    settle(4);
    chk4(outs, 4'h3);
    pm.set_aux(2'h1, 2'h2);
    settle(4);
    chk4(outs, 4'hc);
    pm.set_aux(2'h1, 2'h0);
    for (int h = 1; h < 3; h++) begin
      apb(1'b1, `HBMD_OFS_CONTROL_THREE, 32'(h), rd);
      settle(4);
      chk4(outs, h == 1 ? 4'h3 : 4'hc);
    end
    apb(1'b0, `HBMD_OFS_CONTROL_THREE, 32'h0, rd);
    chk32(rd, 32'h0000_0002);
    apb(1'b1, `HBMD_OFS_CONTROL_THREE, 32'h0, rd);
  endtask
  task automatic t_chop();
    latch(2'h1);
    pm.chop(4);
    settle(4);
    chk4(outs, 4'hf);
  endtask
  task automatic t_hw();
    for (int s = 0; s < 3; s++) begin
      pm.set_aux(s[1:0], 2'h0);
      pm.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
      settle(4);
      pm.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
      settle(5);
      chk4({supply_hw, outs_hw[3], outs_hw[1], 1'b0}, 4'h8);
      settle(10);
      chk4(outs_hw, exp_out(s[1:0], 1'b0, 1'b0));
      pm.set_aux(s[1:0] ^ 2'h1, 2'h0);
      settle(4);
      chk4(outs_hw, exp_out(s[1:0], 1'b0, 1'b0));
    end
    // strap variant now sits in independent mode: hiz bits must not reach its outputs
    apb(1'b1, `HBMD_OFS_CONTROL_THREE, 32'h0000_0003, rd);
    settle(2);
    chk4(outs_hw, 4'ha);
    apb(1'b1, `HBMD_OFS_CONTROL_THREE, 32'h0000_0000, rd);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    settle(14);
    t_regs();
    t_modes();
    t_latch();
    t_gate();
    t_ind();
    t_chop();
    t_hw();
    end_sim();
  end
endmodule // hbmd_decoder_tb
`default_nettype wire
